// >>> rtl/ddr_clk_rst_pkg.sv
// Shared constants and types for the memory PHY clock and reset manager.
package ddr_clk_rst_pkg;

    localparam int REF_CLK_MHZ        = 125;
    localparam int CLK_PERIOD_PS      = 8000;
    localparam int PLL_RESET_NS       = 1000;
    localparam int PLL_RESET_CYCLES   = (PLL_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STEP_PULSE_NS      = 16;
    localparam int STEP_PULSE_CYCLES  = (STEP_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PHASE_STEPS        = 48;
    localparam int SCAN_CLK_MAX_MHZ   = 100;
    localparam int NUM_COUNTERS       = 5;

    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_PHASE_CMD = 8'h04;
    localparam logic [7:0] ADDR_STATUS    = 8'h08;
    localparam logic [7:0] ADDR_PHASE_POS = 8'h0C;
    localparam logic [7:0] ADDR_DLL_FREQ  = 8'h10;

    localparam int CTRL_SOFT_RST_BIT  = 0;
    localparam int CTRL_PLL_RST_BIT   = 1;
    localparam int CTRL_FULL_RATE_BIT = 2;
    localparam int CTRL_AC_PHASE_LSB  = 4;
    localparam int CMD_SEL_LSB        = 0;
    localparam int CMD_UP_BIT         = 3;
    localparam int CMD_COUNT_LSB      = 8;
    localparam int ST_LOCK_BIT        = 0;
    localparam int ST_BUSY_BIT        = 1;
    localparam int ST_SYS_RST_BIT     = 2;
    localparam int ST_SCAN_RST_BIT    = 3;
    localparam int ST_RECFG_RST_BIT   = 4;
    localparam int ST_ERR_BIT         = 5;
    localparam int POS_MEASURE_LSB    = 8;

    localparam logic [2:0] CNT_C0 = 3'h0;
    localparam logic [2:0] CNT_C1 = 3'h1;
    localparam logic [2:0] CNT_C2 = 3'h2;
    localparam logic [2:0] CNT_C3 = 3'h3;
    localparam logic [2:0] CNT_C4 = 3'h4;

    localparam logic [1:0] AC_PHASE_0   = 2'h0;
    localparam logic [1:0] AC_PHASE_90  = 2'h1;
    localparam logic [1:0] AC_PHASE_180 = 2'h2;
    localparam logic [1:0] AC_PHASE_270 = 2'h3;

    localparam logic [5:0] POS_RESET     = 6'h00;
    localparam logic [5:0] POS_LAST      = 6'h2F;
    localparam logic [9:0] DLL_FREQ_RESET = 10'h07D;
    localparam logic [9:0] DLL_LOW_MAX   = 10'h0C8;
    localparam logic [9:0] DLL_MID_MAX   = 10'h12C;

    typedef enum logic [1:0] {DLL_LOW, DLL_MID, DLL_HIGH} dll_mode_t;
    typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_WAIT} step_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       step;
        logic       up;
        logic [2:0] cnt_sel;
    } phase_step_t;

    typedef struct packed {
        logic       full_rate;
        logic [2:0] sys_clk_cnt;
        logic [2:0] mem_clk_cnt;
        logic [2:0] write_clk_cnt;
        logic [2:0] resync_cnt;
        logic [2:0] measure_cnt;
        logic [1:0] ac_phase;
        logic       ac_from_write;
        logic       normal_comp;
    } pll_cfg_t;

endpackage

// >>> rtl/reset_sync.sv
// Reset synchroniser: asynchronous assertion, release through a flip-flop chain.
`timescale 1ns/1ps
module reset_sync #(
    parameter int STAGES = 2
) (
    input  wire logic clk_in,
    input  wire logic arst_in,
    output logic      srst_out
);

    logic [STAGES-1:0] chain_q;

    if (STAGES < 2) begin : g_check
        $error("reset_sync needs at least two stages");
    end

    // Assert at once, release only after the chain has shifted zeros through.
    always_ff @(posedge clk_in or posedge arst_in) begin
        if (arst_in) begin
            chain_q <= '1;
        end else begin
            chain_q <= {chain_q[STAGES-2:0], 1'b0};
        end
    end

    assign srst_out = chain_q[STAGES-1];

endmodule

// >>> rtl/ddr_clk_rst_mgr.sv
// Clock and reset manager for a DDR memory PHY: resets, PLL phase steps, DLL and clock map.
//
// Operation
// - Resets assert asynchronously, release synchronously.
// - Release passes two flip-flops per domain.
// - Scan divider has its own reset synchroniser.
// - Soft reset spares reconfiguration when enable low.
// - Sequence domain resets, PLL and reconfiguration resets.
// - Step read resync and measure clocks independently.
// - Dedicated PLL inputs replace reconfiguration block.
// - DLL centres strobe, setting from frequency.
// - PLL offers at least 48 phase steps.
// - Memory clock on C1 at zero degrees.
// - Write clock on C2 at minus ninety.
// - Read resync clock phase is calibrated, variable.
// - Free-running measure clock on C4, calibrated phase.
// - Address clock phase from memory or write clock.
// - PLL runs in normal compensation mode.
// - Clock phases shift relative during operation.
`timescale 1ns/1ps
module ddr_clk_rst_mgr #(
    parameter int DOMAINS      = 5,
    parameter int SCAN_DIV     = 4,
    parameter bit USE_DEDICATED = 1'b0,
    parameter int PHASE_COUNT  = ddr_clk_rst_pkg::PHASE_STEPS
) (
    input  wire logic                          ref_clk_in,
    input  wire logic                          rst_in,
    input  wire ddr_clk_rst_pkg::reg_req_t     reg_req_in,
    output logic [31:0]                        reg_rdata_out,
    input  wire logic                          pll_locked_in,
    input  wire logic                          phase_done_in,
    input  wire logic                          reconfig_soft_reset_en_in,
    input  wire logic [DOMAINS-1:0]            domain_clk_in,
    output logic [DOMAINS-1:0]                 domain_rst_out,
    output logic                               sys_rst_out,
    output logic                               pll_reset_out,
    output logic                               reconfig_rst_out,
    output logic                               scan_clk_out,
    output ddr_clk_rst_pkg::phase_step_t       pll_step_out,
    output ddr_clk_rst_pkg::phase_step_t       reconfig_step_out,
    output ddr_clk_rst_pkg::pll_cfg_t          pll_cfg_out,
    output ddr_clk_rst_pkg::dll_mode_t         dll_mode_out
);

    localparam int NC = ddr_clk_rst_pkg::NUM_COUNTERS;

    if (PHASE_COUNT < ddr_clk_rst_pkg::PHASE_STEPS || PHASE_COUNT > 64) begin : g_chk_phase
        $error("PHASE_COUNT must lie between 48 and 64");
    end
    if (SCAN_DIV < 2 || (SCAN_DIV % 2) != 0 ||
        ddr_clk_rst_pkg::REF_CLK_MHZ / SCAN_DIV >= ddr_clk_rst_pkg::SCAN_CLK_MAX_MHZ) begin : g_chk_div
        $error("SCAN_DIV must be even and keep the scan clock below its limit");
    end
    if (DOMAINS < 1) begin : g_chk_dom
        $error("DOMAINS must be at least one");
    end

    // Phase position wraps modulo the number of PLL phase steps.
    function automatic logic [5:0] step_pos(input logic [5:0] pos, input logic up);
        logic [5:0] last;
        last = 6'(PHASE_COUNT - 1);
        if (up) begin
            step_pos = (pos == last) ? 6'h00 : 6'(pos + 6'h01);
        end else begin
            step_pos = (pos == 6'h00) ? last : 6'(pos - 6'h01);
        end
    endfunction

    // Reconfiguration path reaches only the calibrated clocks; dedicated inputs reach all.
    function automatic logic sel_ok(input logic [2:0] sel);
        if (USE_DEDICATED) begin
            sel_ok = (sel <= ddr_clk_rst_pkg::CNT_C4);
        end else begin
            sel_ok = (sel == ddr_clk_rst_pkg::CNT_C3) || (sel == ddr_clk_rst_pkg::CNT_C4);
        end
    endfunction

    // DLL delay setting picked from the interface frequency.
    function automatic ddr_clk_rst_pkg::dll_mode_t dll_for(input logic [9:0] mhz);
        if (mhz <= ddr_clk_rst_pkg::DLL_LOW_MAX) begin
            dll_for = ddr_clk_rst_pkg::DLL_LOW;
        end else if (mhz <= ddr_clk_rst_pkg::DLL_MID_MAX) begin
            dll_for = ddr_clk_rst_pkg::DLL_MID;
        end else begin
            dll_for = ddr_clk_rst_pkg::DLL_HIGH;
        end
    endfunction

    logic                        soft_reset_q;
    logic                        full_rate_q;
    logic [1:0]                  ac_phase_q;
    logic [9:0]                  dll_freq_q;
    logic                        err_q;
    logic                        pll_reset_q;
    logic [15:0]                 prst_cnt_q;
    logic [31:0]                 rdata_q;
    logic [31:0]                 rdata_d;
    logic                        ctrl_wr;
    logic                        cmd_wr;
    logic                        manual_pll_rst;
    logic                        cmd_ok;
    logic                        phy_arst;
    logic                        reconfig_arst;
    logic                        scan_rst;
    logic                        reconfig_rst;
    logic                        scan_clk_q;
    logic [7:0]                  scan_cnt_q;
    ddr_clk_rst_pkg::step_state_t state_q;
    logic [1:0]                  pulse_cnt_q;
    logic [5:0]                  remain_q;
    logic [2:0]                  sel_q;
    logic                        up_q;
    logic [5:0]                  pos_q [NC];
    ddr_clk_rst_pkg::pll_cfg_t   cfg_q;
    ddr_clk_rst_pkg::dll_mode_t  dll_q;
    ddr_clk_rst_pkg::phase_step_t step_now;

    assign ctrl_wr        = reg_req_in.wr && reg_req_in.addr == ddr_clk_rst_pkg::ADDR_CTRL;
    assign cmd_wr         = reg_req_in.wr && reg_req_in.addr == ddr_clk_rst_pkg::ADDR_PHASE_CMD;
    assign manual_pll_rst = ctrl_wr && reg_req_in.wdata[ddr_clk_rst_pkg::CTRL_PLL_RST_BIT];
    assign cmd_ok         = state_q == ddr_clk_rst_pkg::ST_IDLE &&
                            sel_ok(reg_req_in.wdata[ddr_clk_rst_pkg::CMD_SEL_LSB +: 3]);

    // PHY resets follow reset, soft reset, PLL reset and loss of lock.
    assign phy_arst      = rst_in | soft_reset_q | pll_reset_q | ~pll_locked_in;
    assign reconfig_arst = rst_in | (soft_reset_q & reconfig_soft_reset_en_in);

    reset_sync #(
        .STAGES (2)
    ) u_sys_sync (
        .clk_in   (ref_clk_in),
        .arst_in  (phy_arst),
        .srst_out (sys_rst_out)
    );

    reset_sync #(
        .STAGES (2)
    ) u_scan_sync (
        .clk_in   (ref_clk_in),
        .arst_in  (rst_in),
        .srst_out (scan_rst)
    );

    reset_sync #(
        .STAGES (2)
    ) u_recfg_sync (
        .clk_in   (ref_clk_in),
        .arst_in  (reconfig_arst),
        .srst_out (reconfig_rst)
    );

    for (genvar d = 0; d < DOMAINS; d++) begin : g_dom
        reset_sync #(
            .STAGES (2)
        ) u_dom_sync (
            .clk_in   (domain_clk_in[d]),
            .arst_in  (phy_arst),
            .srst_out (domain_rst_out[d])
        );
    end

    assign reconfig_rst_out = reconfig_rst;

    // Control register; stays writable while the PHY is held in soft reset.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            soft_reset_q <= 1'b0;
            full_rate_q  <= 1'b0;
            ac_phase_q   <= ddr_clk_rst_pkg::AC_PHASE_0;
        end else if (ctrl_wr) begin
            soft_reset_q <= reg_req_in.wdata[ddr_clk_rst_pkg::CTRL_SOFT_RST_BIT];
            full_rate_q  <= reg_req_in.wdata[ddr_clk_rst_pkg::CTRL_FULL_RATE_BIT];
            ac_phase_q   <= reg_req_in.wdata[ddr_clk_rst_pkg::CTRL_AC_PHASE_LSB +: 2];
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dll_freq_q <= ddr_clk_rst_pkg::DLL_FREQ_RESET;
        end else if (reg_req_in.wr && reg_req_in.addr == ddr_clk_rst_pkg::ADDR_DLL_FREQ) begin
            dll_freq_q <= reg_req_in.wdata[9:0];
        end
    end

    // Refused phase commands raise a sticky error; a new refusal wins over the clear.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            err_q <= 1'b0;
        end else if (cmd_wr && !cmd_ok) begin
            err_q <= 1'b1;
        end else if (reg_req_in.wr && reg_req_in.addr == ddr_clk_rst_pkg::ADDR_STATUS &&
                     reg_req_in.wdata[ddr_clk_rst_pkg::ST_ERR_BIT]) begin
            err_q <= 1'b0;
        end
    end

    // PLL reset pulse at power-up and on each manual request.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            prst_cnt_q  <= 16'(ddr_clk_rst_pkg::PLL_RESET_CYCLES);
            pll_reset_q <= 1'b1;
        end else if (manual_pll_rst) begin
            prst_cnt_q  <= 16'(ddr_clk_rst_pkg::PLL_RESET_CYCLES);
            pll_reset_q <= 1'b1;
        end else if (prst_cnt_q != 16'h0000) begin
            prst_cnt_q  <= 16'(prst_cnt_q - 16'h0001);
            pll_reset_q <= prst_cnt_q != 16'h0001;
        end
    end

    assign pll_reset_out = pll_reset_q;

    // Scan clock divided down from the reference clock under its own reset.
    always_ff @(posedge ref_clk_in or posedge scan_rst) begin
        if (scan_rst) begin
            scan_cnt_q <= 8'h00;
            scan_clk_q <= 1'b0;
        end else if (scan_cnt_q == 8'(SCAN_DIV / 2 - 1)) begin
            scan_cnt_q <= 8'h00;
            scan_clk_q <= ~scan_clk_q;
        end else begin
            scan_cnt_q <= 8'(scan_cnt_q + 8'h01);
        end
    end

    assign scan_clk_out = scan_clk_q;

    // Phase stepping engine: one pulse per step, then wait for the PLL to finish it.
    always_ff @(posedge ref_clk_in or posedge reconfig_rst) begin
        if (reconfig_rst) begin
            state_q     <= ddr_clk_rst_pkg::ST_IDLE;
            pulse_cnt_q <= 2'h0;
            remain_q    <= 6'h00;
            sel_q       <= ddr_clk_rst_pkg::CNT_C3;
            up_q        <= 1'b0;
        end else begin
            case (state_q)
                ddr_clk_rst_pkg::ST_IDLE: begin
                    if (cmd_wr && cmd_ok && reg_req_in.wdata[ddr_clk_rst_pkg::CMD_COUNT_LSB +: 6] != 6'h00) begin
                        state_q     <= ddr_clk_rst_pkg::ST_PULSE;
                        pulse_cnt_q <= 2'(ddr_clk_rst_pkg::STEP_PULSE_CYCLES - 1);
                        remain_q    <= reg_req_in.wdata[ddr_clk_rst_pkg::CMD_COUNT_LSB +: 6];
                        sel_q       <= reg_req_in.wdata[ddr_clk_rst_pkg::CMD_SEL_LSB +: 3];
                        up_q        <= reg_req_in.wdata[ddr_clk_rst_pkg::CMD_UP_BIT];
                    end
                end
                ddr_clk_rst_pkg::ST_PULSE: begin
                    if (pulse_cnt_q == 2'h0) begin
                        state_q <= ddr_clk_rst_pkg::ST_WAIT;
                    end else begin
                        pulse_cnt_q <= 2'(pulse_cnt_q - 2'h1);
                    end
                end
                ddr_clk_rst_pkg::ST_WAIT: begin
                    if (phase_done_in) begin
                        remain_q    <= 6'(remain_q - 6'h01);
                        pulse_cnt_q <= 2'(ddr_clk_rst_pkg::STEP_PULSE_CYCLES - 1);
                        state_q     <= (remain_q == 6'h01) ? ddr_clk_rst_pkg::ST_IDLE
                                                           : ddr_clk_rst_pkg::ST_PULSE;
                    end
                end
                default: begin
                    state_q <= ddr_clk_rst_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Tracked phase of each counter; a PLL reset restores the compiled phases.
    always_ff @(posedge ref_clk_in or posedge reconfig_rst) begin
        if (reconfig_rst) begin
            for (int i = 0; i < NC; i++) begin
                pos_q[i] <= ddr_clk_rst_pkg::POS_RESET;
            end
        end else if (pll_reset_q) begin
            for (int i = 0; i < NC; i++) begin
                pos_q[i] <= ddr_clk_rst_pkg::POS_RESET;
            end
        end else if (state_q == ddr_clk_rst_pkg::ST_WAIT && phase_done_in) begin
            pos_q[sel_q] <= step_pos(pos_q[sel_q], up_q);
        end
    end

    assign step_now.step    = state_q == ddr_clk_rst_pkg::ST_PULSE;
    assign step_now.up      = up_q;
    assign step_now.cnt_sel = sel_q;

    // Only one of the two stepping paths exists in a given build.
    assign pll_step_out      = USE_DEDICATED ? step_now : '0;
    assign reconfig_step_out = USE_DEDICATED ? '0 : step_now;

    // Static clock map and DLL setting, registered.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_q <= '0;
            dll_q <= ddr_clk_rst_pkg::DLL_LOW;
        end else begin
            cfg_q.full_rate     <= full_rate_q;
            cfg_q.sys_clk_cnt   <= full_rate_q ? ddr_clk_rst_pkg::CNT_C1 : ddr_clk_rst_pkg::CNT_C0;
            cfg_q.mem_clk_cnt   <= ddr_clk_rst_pkg::CNT_C1;
            cfg_q.write_clk_cnt <= ddr_clk_rst_pkg::CNT_C2;
            cfg_q.resync_cnt    <= ddr_clk_rst_pkg::CNT_C3;
            cfg_q.measure_cnt   <= ddr_clk_rst_pkg::CNT_C4;
            cfg_q.ac_phase      <= ac_phase_q;
            cfg_q.ac_from_write <= ac_phase_q == ddr_clk_rst_pkg::AC_PHASE_90 ||
                                   ac_phase_q == ddr_clk_rst_pkg::AC_PHASE_270;
            cfg_q.normal_comp   <= 1'b1;
            dll_q               <= dll_for(dll_freq_q);
        end
    end

    assign pll_cfg_out  = cfg_q;
    assign dll_mode_out = dll_q;

    // Read multiplexer; unmapped addresses read zero.
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (reg_req_in.addr == ddr_clk_rst_pkg::ADDR_CTRL) begin
            rdata_d[ddr_clk_rst_pkg::CTRL_SOFT_RST_BIT]     = soft_reset_q;
            rdata_d[ddr_clk_rst_pkg::CTRL_FULL_RATE_BIT]    = full_rate_q;
            rdata_d[ddr_clk_rst_pkg::CTRL_AC_PHASE_LSB +: 2] = ac_phase_q;
        end else if (reg_req_in.addr == ddr_clk_rst_pkg::ADDR_PHASE_CMD) begin
            rdata_d[ddr_clk_rst_pkg::CMD_SEL_LSB +: 3]   = sel_q;
            rdata_d[ddr_clk_rst_pkg::CMD_UP_BIT]         = up_q;
            rdata_d[ddr_clk_rst_pkg::CMD_COUNT_LSB +: 6] = remain_q;
        end else if (reg_req_in.addr == ddr_clk_rst_pkg::ADDR_STATUS) begin
            rdata_d[ddr_clk_rst_pkg::ST_LOCK_BIT]      = pll_locked_in;
            rdata_d[ddr_clk_rst_pkg::ST_BUSY_BIT]      = state_q != ddr_clk_rst_pkg::ST_IDLE;
            rdata_d[ddr_clk_rst_pkg::ST_SYS_RST_BIT]   = sys_rst_out;
            rdata_d[ddr_clk_rst_pkg::ST_SCAN_RST_BIT]  = scan_rst;
            rdata_d[ddr_clk_rst_pkg::ST_RECFG_RST_BIT] = reconfig_rst;
            rdata_d[ddr_clk_rst_pkg::ST_ERR_BIT]       = err_q;
        end else if (reg_req_in.addr == ddr_clk_rst_pkg::ADDR_PHASE_POS) begin
            rdata_d[5:0] = pos_q[ddr_clk_rst_pkg::CNT_C3];
            rdata_d[ddr_clk_rst_pkg::POS_MEASURE_LSB +: 6] = pos_q[ddr_clk_rst_pkg::CNT_C4];
        end else if (reg_req_in.addr == ddr_clk_rst_pkg::ADDR_DLL_FREQ) begin
            rdata_d[9:0] = dll_freq_q;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= reg_req_in.rd ? rdata_d : 32'h0000_0000;
        end
    end

    assign reg_rdata_out = rdata_q;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_arst_fell;
        $fell(phy_arst) ##1 !phy_arst;
    endsequence

    sequence s_arst_low_two;
        s_arst_fell ##1 !phy_arst;
    endsequence

    property p_sys_rst_assert;
        phy_arst |-> sys_rst_out;
    endproperty
    a_sys_rst_assert: assert property (p_sys_rst_assert) else $error("System reset not asserted.");

    property p_sys_rst_hold;
        s_arst_fell |-> sys_rst_out;
    endproperty
    a_sys_rst_hold: assert property (p_sys_rst_hold) else $error("System reset released too early.");

    property p_sys_rst_release;
        s_arst_low_two |-> !sys_rst_out;
    endproperty
    a_sys_rst_release: assert property (p_sys_rst_release) else $error("System reset released late.");

    property p_scan_ignores_soft;
        (!scan_rst && soft_reset_q) |=> !scan_rst;
    endproperty
    a_scan_ignores_soft: assert property (p_scan_ignores_soft) else $error("Scan reset followed soft reset.");

    property p_recfg_spared;
        (soft_reset_q && !reconfig_soft_reset_en_in && !reconfig_rst) ##1 !reconfig_soft_reset_en_in
            |-> !reconfig_rst;
    endproperty
    a_recfg_spared: assert property (p_recfg_spared) else $error("Reconfiguration reset by soft reset.");

    property p_pll_rst_manual;
        manual_pll_rst |=> pll_reset_out ##1 pll_reset_out;
    endproperty
    a_pll_rst_manual: assert property (p_pll_rst_manual) else $error("Manual PLL reset not driven.");

    property p_unlock_holds;
        (!pll_locked_in || pll_reset_out) |-> sys_rst_out;
    endproperty
    a_unlock_holds: assert property (p_unlock_holds) else $error("Reset released without lock.");

    property p_step_pulse;
        $rose(step_now.step) |-> step_now.step ##1 step_now.step ##1 !step_now.step;
    endproperty
    a_step_pulse: assert property (p_step_pulse) else $error("Phase step pulse has wrong width.");

    property p_path_exclusive;
        USE_DEDICATED ? !reconfig_step_out.step : !pll_step_out.step;
    endproperty
    a_path_exclusive: assert property (p_path_exclusive) else $error("Unused step path was driven.");

    property p_pos_wrap;
        (state_q == ddr_clk_rst_pkg::ST_WAIT && phase_done_in && !pll_reset_q &&
         pos_q[sel_q] == (up_q ? 6'(PHASE_COUNT - 1) : 6'h00)) |=>
            pos_q[$past(sel_q)] == ($past(up_q) ? 6'h00 : 6'(PHASE_COUNT - 1));
    endproperty
    a_pos_wrap: assert property (p_pos_wrap) else $error("Phase position did not wrap.");

    property p_ac_source;
        (ac_phase_q == ddr_clk_rst_pkg::AC_PHASE_270 && $stable(ac_phase_q)) |=> pll_cfg_out.ac_from_write;
    endproperty
    a_ac_source: assert property (p_ac_source) else $error("Address clock source wrong.");

endmodule

// >>> testbench/pll_model.sv
// Stand-in for the PLL: lock after its reset, step completion, output clocks.
`timescale 1ns/1ps
module pll_model (
    input  wire logic       clk_in,
    input  wire logic       pll_reset_in,
    input  wire logic       step_in,
    output logic            locked_out,
    output logic            done_out,
    output logic [4:0]      clk_out
);
    logic [3:0] lock_q = 4'h0;
    logic [3:0] step_q = 4'h0;
    logic [4:0] div_q  = 5'h0;
    always @(posedge clk_in) begin
        lock_q  <= pll_reset_in ? 4'h0 : lock_q + {3'h0, ~&lock_q};
        step_q  <= {step_q[2:0], step_in};
        div_q   <= div_q + 5'h1;
    end
    assign clk_out    = div_q;
    assign locked_out = &lock_q;
    assign done_out   = step_q[3] & ~step_q[2];
endmodule

// >>> testbench/ddr_clk_rst_mgr_tb.sv
// Self-checking bench for the memory PHY clock and reset manager.
`timescale 1ns/1ps
module ddr_clk_rst_mgr_tb;
    logic                         ref_clk_in = 1'b0;
    logic                         rst_in     = 1'b1;
    logic                         en         = 1'b1;
    ddr_clk_rst_pkg::reg_req_t    req        = '0;
    ddr_clk_rst_pkg::phase_step_t ps, rs;
    ddr_clk_rst_pkg::pll_cfg_t    cfg;
    ddr_clk_rst_pkg::dll_mode_t   dm;
    logic [31:0]                  rdat, v;
    logic [4:0]                   dclk, drst;
    logic                         lk, dn, srst, prst, crst, sclk;
    int                           scan_edges = 0;
    int                           bad_count = 0;
    int                           tests_run = 0;
    logic [31:0] rows [4][4] = '{'{32'h10, 32'hC8, 32'hC8, 32'h0}, '{32'h10, 32'hC9, 32'hC9, 32'h1},
                                 '{32'h10, 32'h12D, 32'h12D, 32'h2}, '{32'h20, 32'h5, 32'h0, 32'h2}};
    always #4 ref_clk_in = ~ref_clk_in;
    always @(posedge sclk) scan_edges++;
    ddr_clk_rst_mgr u_ddr_clk_rst_mgr (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_req_in(req),
        .reg_rdata_out(rdat), .pll_locked_in(lk), .phase_done_in(dn), .reconfig_soft_reset_en_in(en),
        .domain_clk_in(dclk), .domain_rst_out(drst), .sys_rst_out(srst), .pll_reset_out(prst),
        .reconfig_rst_out(crst), .scan_clk_out(sclk), .pll_step_out(ps), .reconfig_step_out(rs),
        .pll_cfg_out(cfg), .dll_mode_out(dm));
    pll_model u_pll_model (.clk_in(ref_clk_in), .pll_reset_in(prst), .step_in(ps.step | rs.step),
        .locked_out(lk), .done_out(dn), .clk_out(dclk));
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in) req <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk_in) req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_in) req <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge ref_clk_in) req <= '0;
        @(negedge ref_clk_in) d = rdat;
    endtask
    task automatic idle;
        logic [31:0] s;
        for (int i = 0; i < 40; i++) begin
            rd(8'h08, s);
            if (s[1] === 1'b0) return;
        end
        bad_count++;
        test_done;
    endtask
    task automatic released;
        for (int i = 0; i < 400; i++) begin
            @(negedge ref_clk_in);
            if (srst === 1'b0 && drst === 5'h0) return;
        end
        bad_count++;
        test_done;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(negedge ref_clk_in);
        chk({prst, srst, drst}, 32'h7F);
        released;
        chk(crst, 32'h0);
        chk({cfg.mem_clk_cnt, cfg.write_clk_cnt, cfg.resync_cnt, cfg.measure_cnt, cfg.normal_comp}, 32'h539);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            wr(rows[i][0][7:0], rows[i][1]);
            rd(rows[i][0][7:0], v);
            chk(v, rows[i][2]);
            chk(dm, rows[i][3]);
        end
        $display("table test done");
        wr(8'h00, 32'h34);
        repeat (2) @(negedge ref_clk_in);
        chk({cfg.full_rate, cfg.sys_clk_cnt, cfg.ac_phase, cfg.ac_from_write}, 32'h4F);
        wr(8'h00, 32'h20);
        repeat (2) @(negedge ref_clk_in);
        chk({cfg.full_rate, cfg.sys_clk_cnt, cfg.ac_phase, cfg.ac_from_write}, 32'h4);
        $display("clock map test done");
        wr(8'h04, 32'h10B);
        idle;
        rd(8'h0C, v);
        chk(v, 32'h1);
        wr(8'h04, 32'h104);
        idle;
        rd(8'h0C, v);
        chk(v, 32'h2F01);
        wr(8'h04, 32'h101);
        rd(8'h08, v);
        chk(v[5], 32'h1);
        chk(ps, 32'h0);
        $display("phase test done");
        @(posedge ref_clk_in) en <= 1'b0;
        wr(8'h00, 32'h1);
        @(negedge ref_clk_in);
        chk({srst, crst}, 32'h2);
        v = scan_edges;
        repeat (16) @(negedge ref_clk_in);
        chk(scan_edges - v, 32'h4);
        @(posedge ref_clk_in) en <= 1'b1;
        repeat (3) @(negedge ref_clk_in);
        chk(crst, 32'h1);
        wr(8'h00, 32'h0);
        released;
        $display("soft reset test done");
        wr(8'h04, 32'h10B);
        idle;
        rd(8'h0C, v);
        chk(v, 32'h1);
        wr(8'h00, 32'h2);
        @(negedge ref_clk_in);
        chk({prst, srst}, 32'h3);
        released;
        rd(8'h0C, v);
        chk(v, 32'h0);
        $display("pll reset test done");
        test_done;
    end
endmodule
